// [rtl/ixb_pkg.sv]
`default_nettype none
package ixb_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned RESET_TIME_US   = 1000;
  localparam int unsigned RESET_CYCLES    = (CLK_HZ / 1_000_000) * RESET_TIME_US;
  localparam int unsigned RDY_TIMER_CYC   = 4;
  localparam int unsigned RST_CNT_W       = 14;
  localparam int unsigned RDY_CNT_W       = 4;
  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  DMA_ACK_IDLE    = 3'h4;
  localparam logic [15:0] PORT_RANGE_BASE = 16'h0800;
  localparam logic [15:0] PORT_RANGE_TOP  = 16'h08ff;
  localparam int unsigned STRAP_BIT_POS   = 2;
  // ----------------------------------------------------------------
  // cycle kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IXB_MEM_RD, IXB_MEM_WR, IXB_IO_RD, IXB_IO_WR} ixb_kind_t;
endpackage
`default_nettype wire

// [rtl/ixb_cyc_if.sv]
`default_nettype none
interface ixb_cyc_if;
  logic start;
  logic ready_in;
  logic zws_n_in;
  logic busy;
  logic done;
  modport ctl (input start, input ready_in, input zws_n_in, output busy, output done);
  modport top (output start, output ready_in, output zws_n_in, input busy, input done);
endinterface
`default_nettype wire

// [rtl/ixb_cycle_timer.sv]
`default_nettype none
// ----------------------------------------------------------------
// cycle length timer: default count, stretched by ready, cut by zws
// ----------------------------------------------------------------
module ixb_cycle_timer #(
  parameter int unsigned DEFAULT_CYC = ixb_pkg::RDY_TIMER_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // cycle control
  ixb_cyc_if.ctl   cyc
);
  typedef struct packed {
    logic                           busy;
    logic                           done;
    logic [ixb_pkg::RDY_CNT_W-1:0]  cnt;
  } ixb_tmr_t;

  ixb_tmr_t s_q;
  ixb_tmr_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy)
    begin
      if (cyc.start)
      begin
        s_d.busy = 1'b1;
        s_d.cnt  = ixb_pkg::RDY_CNT_W'(DEFAULT_CYC);
      end
    end
    else if (!cyc.zws_n_in)
    begin
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
    end
    else if (s_q.cnt != '0)
    begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    else if (cyc.ready_in)
    begin
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign cyc.busy = s_q.busy;
  assign cyc.done = s_q.done;
endmodule
`default_nettype wire

// [rtl/ixb_ctrl.sv]
`default_nettype none
// Summary of operation
// - a slave holding ready low stretches the cycle past the default timer.
// - zero-wait-state from a slave ends the cycle before the timer expires.
// - address latch enable marks a valid address on the bus.
// - address enable stays high throughout DMA cycles.
// - terminal count is driven when the active DMA count runs out.
// - encoded acknowledge carries the winning channel, idle value 100b.
// - mode strap sampled after power-up picks reset or activity function.
// - alternate mode drives bus reset for 1 ms after power-good, hot reset, reset drive.
// - alternate mode bus reset follows the inverse of host PCI reset.
// - PC mode drives activity indicator on any selected break event.
// - xbus read low passes xbus data onto system data.
// - xbus read pin is sampled after reset, in either mode, into port bit 2.
// - buffer enable active whenever an access decodes to the xbus.
// - alternate mode first select is boot ROM chip select, default timing.
// - alternate mode second select covers I/O ports 800h to 8FFh.
// - PC mode both selects form a two-bit encoded xbus address.
module ixb_ctrl #(
  parameter int unsigned RESET_CYC = ixb_pkg::RESET_CYCLES
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // host side cycle request
  input  wire logic              cyc_start,
  input  wire ixb_pkg::ixb_kind_t cyc_kind,
  input  wire logic [15:0]       cyc_addr,
  input  wire logic              cyc_dma,
  input  wire logic              cyc_is_xbus,
  input  wire logic              cyc_is_rom,
  input  wire logic [1:0]        cyc_xbus_dev,
  output logic                   cyc_busy,
  output logic                   cyc_done,
  // dma controller side
  input  wire logic              dma_grant,
  input  wire logic [2:0]        dma_channel,
  input  wire logic              dma_count_zero,
  // reset and power management sources
  input  wire logic              pci_reset_n,
  input  wire logic              hot_reset_set,
  input  wire logic              reset_drive_set,
  input  wire logic [31:0]       break_event_enable,
  input  wire logic [31:0]       break_event_src,
  // pins in
  input  wire logic              power_good_in,
  input  wire logic              mode_strap_in,
  input  wire logic              iochrdy_in,
  input  wire logic              zws_n_in,
  input  wire logic              xbus_read_n_in,
  // isa pins out
  output logic                   bale_out,
  output logic                   aen_out,
  output logic                   tc_out,
  output logic [2:0]             encoded_dma_ack,
  output logic                   bus_reset_out,
  output logic                   power_mgmt_active_n,
  // xbus pins out
  output logic                   xbus_read_n,
  output logic                   xbus_read_n_oe_n,
  output logic                   xbus_buffer_enable_n,
  output logic                   xbus_select_lo,
  output logic                   xbus_select_hi,
  // status
  output logic                   alt_mode,
  output logic                   strap_sense_bit
);
  typedef struct packed {
    logic [1:0]               pg_s;
    logic [1:0]               rdy_s;
    logic [1:0]               zws_s;
    logic [1:0]               xrd_s;
    logic [1:0]               strap_s;
    logic                     pg_prev;
    logic                     settle;
    logic                     sampled;
    logic                     alt;
    logic                     sense;
    logic                     strap_due;
    logic                     oe_n;
    logic [ixb_pkg::RST_CNT_W-1:0] rst_cnt;
    logic                     active;
    logic                     bale;
    logic                     aen;
    logic                     tc;
    logic [2:0]               ack;
    logic                     busrst;
    logic                     power_mgmt_active_n_n;
    logic                     xrd_n;
    logic                     xoe_n;
    logic                     sel_lo;
    logic                     sel_hi;
    logic                     done;
    logic                     xbus;
    logic                     rd;
    logic                     rom;
    logic                     prt;
    logic [1:0]               dev;
  } ixb_st_t;

  ixb_st_t s_q;
  ixb_st_t s_d;
  ixb_cyc_if cyc ();

  function automatic logic in_port_range(input logic [15:0] a);
    in_port_range = (a >= ixb_pkg::PORT_RANGE_BASE) && (a <= ixb_pkg::PORT_RANGE_TOP);
  endfunction

  assign cyc.start    = cyc_start && !s_q.active;
  assign cyc.ready_in = s_q.rdy_s[1];
  assign cyc.zws_n_in = s_q.zws_s[1];

  ixb_cycle_timer u_tmr (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cyc     (cyc)
  );

  always_comb
  begin
    s_d         = s_q;
    s_d.pg_s    = {s_q.pg_s[0], power_good_in};
    s_d.rdy_s   = {s_q.rdy_s[0], iochrdy_in};
    s_d.zws_s   = {s_q.zws_s[0], zws_n_in};
    s_d.xrd_s   = {s_q.xrd_s[0], xbus_read_n_in};
    s_d.strap_s = {s_q.strap_s[0], mode_strap_in};
    s_d.pg_prev = s_q.pg_s[1];
    s_d.done    = cyc.done;
    s_d.bale    = 1'b0;
    // ----------------------------------------------------------------
    // strap sampling after reset release
    // ----------------------------------------------------------------
    // wait until the synchronisers carry pin levels, not their reset values
    if (!s_q.settle)
    begin
      s_d.settle = 1'b1;
    end
    else if (!s_q.sampled)
    begin
      s_d.sampled   = 1'b1;
      s_d.strap_due = 1'b1;
    end
    else if (s_q.strap_due)
    begin
      s_d.strap_due = 1'b0;
      s_d.alt       = s_q.strap_s[1];
      s_d.sense     = s_q.xrd_s[1];
    end
    // read pin stays released until its strap level has been taken
    s_d.oe_n = !s_d.sampled || s_d.strap_due;
    // ----------------------------------------------------------------
    // bus reset stretch
    // ----------------------------------------------------------------
    if ((s_q.pg_s[1] && !s_q.pg_prev) || hot_reset_set || reset_drive_set)
      s_d.rst_cnt = ixb_pkg::RST_CNT_W'(RESET_CYC);
    else if (s_q.rst_cnt != '0)
      s_d.rst_cnt = s_q.rst_cnt - 1'b1;
    s_d.busrst  = s_q.alt && (!pci_reset_n || (s_d.rst_cnt != '0));
    s_d.power_mgmt_active_n_n = s_q.alt || ((break_event_enable & break_event_src) == '0);
    // ----------------------------------------------------------------
    // dma indications
    // ----------------------------------------------------------------
    s_d.ack = dma_grant ? dma_channel : ixb_pkg::DMA_ACK_IDLE;
    s_d.tc  = dma_grant && dma_count_zero;
    // ----------------------------------------------------------------
    // bus cycle
    // ----------------------------------------------------------------
    if (cyc.start)
    begin
      s_d.active = 1'b1;
      s_d.bale   = 1'b1;
      s_d.aen    = cyc_dma;
      s_d.xbus   = cyc_is_xbus || (s_q.alt && (cyc_is_rom ||
                   (cyc_kind inside {ixb_pkg::IXB_IO_RD, ixb_pkg::IXB_IO_WR} &&
                    in_port_range(cyc_addr))));
      s_d.rd     = cyc_kind inside {ixb_pkg::IXB_MEM_RD, ixb_pkg::IXB_IO_RD};
      s_d.rom    = cyc_is_rom && cyc_kind inside {ixb_pkg::IXB_MEM_RD, ixb_pkg::IXB_MEM_WR};
      s_d.prt    = cyc_kind inside {ixb_pkg::IXB_IO_RD, ixb_pkg::IXB_IO_WR} &&
                   in_port_range(cyc_addr);
      s_d.dev    = cyc_xbus_dev;
    end
    else if (cyc.done)
    begin
      s_d.active = 1'b0;
      s_d.aen    = 1'b0;
      s_d.xbus   = 1'b0;
      s_d.rom    = 1'b0;
      s_d.prt    = 1'b0;
      s_d.rd     = 1'b0;
    end
    s_d.xoe_n = !s_d.xbus;
    s_d.xrd_n = !(s_d.xbus && s_d.rd);
    if (s_q.alt)
    begin
      s_d.sel_lo = s_d.rom;
      s_d.sel_hi = s_d.prt;
    end
    else
    begin
      s_d.sel_lo = s_d.xbus & s_d.dev[0];
      s_d.sel_hi = s_d.xbus & s_d.dev[1];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q         <= '0;
      s_q.ack     <= ixb_pkg::DMA_ACK_IDLE;
      s_q.power_mgmt_active_n_n <= 1'b1;
      s_q.xrd_n   <= 1'b1;
      s_q.xoe_n   <= 1'b1;
      s_q.oe_n    <= 1'b1;
      s_q.pg_s    <= 2'h0;
      s_q.rdy_s   <= 2'h3;
      s_q.zws_s   <= 2'h3;
      s_q.xrd_s   <= 2'h3;
    end
    else
      s_q <= s_d;
  end

  assign cyc_busy             = s_q.active;
  assign cyc_done             = s_q.done;
  assign bale_out             = s_q.bale;
  assign aen_out              = s_q.aen;
  assign tc_out               = s_q.tc;
  assign encoded_dma_ack      = s_q.ack;
  assign bus_reset_out        = s_q.busrst;
  assign power_mgmt_active_n  = s_q.power_mgmt_active_n_n;
  assign xbus_read_n          = s_q.xrd_n;
  assign xbus_read_n_oe_n     = s_q.oe_n;
  assign xbus_buffer_enable_n = s_q.xoe_n;
  assign xbus_select_lo       = s_q.sel_lo;
  assign xbus_select_hi       = s_q.sel_hi;
  assign alt_mode             = s_q.alt;
  assign strap_sense_bit      = s_q.sense;
endmodule
`default_nettype wire

// [test/ixb_chk.sv]
`default_nettype none
module ixb_chk (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_n,
  // host side
  input wire logic               cyc_start,
  input wire ixb_pkg::ixb_kind_t cyc_kind,
  input wire logic [15:0]        cyc_addr,
  input wire logic               cyc_dma,
  input wire logic               cyc_is_xbus,
  input wire logic               cyc_busy,
  input wire logic               cyc_done,
  input wire logic               dma_grant,
  input wire logic [2:0]         dma_channel,
  // pins
  input wire logic               iochrdy_in,
  input wire logic               zws_n_in,
  input wire logic               alt_mode,
  input wire logic               bale_out,
  input wire logic               aen_out,
  input wire logic [2:0]         encoded_dma_ack,
  input wire logic               bus_reset_out,
  input wire logic               power_mgmt_active_n,
  input wire logic               xbus_read_n,
  input wire logic               xbus_buffer_enable_n,
  input wire logic               xbus_select_hi
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic take;
  assign take = cyc_start && !cyc_busy;
  a_bale_pulse: assert property (take |-> ##[1:2] bale_out ##1 !bale_out)
    else $error("address latch pulse wrong");
  a_aen_dma: assert property (take && cyc_dma |-> ##[1:2] aen_out)
    else $error("address enable missing in dma cycle");
  a_ack_channel: assert property (dma_grant |=> encoded_dma_ack == $past(dma_channel))
    else $error("encoded ack not the channel");
  a_zws_early: assert property (take && !zws_n_in |-> ##[1:6] cyc_done)
    else $error("zero wait cycle not cut short");
  a_ready_hold: assert property ((take && !iochrdy_in && zws_n_in) ##1
    (!iochrdy_in && zws_n_in) [*7] |=> !cyc_done) else $error("cycle ended with ready low");
  a_mode_split: assert property (alt_mode ? power_mgmt_active_n : !bus_reset_out)
    else $error("shared pin used in wrong mode");
  a_xrd_in_cycle: assert property (!xbus_read_n |-> cyc_busy)
    else $error("xbus read low outside a cycle");
  a_xoe_decode: assert property (take && cyc_is_xbus |-> ##[1:2] !xbus_buffer_enable_n)
    else $error("xbus buffer not enabled");
  a_port_range: assert property (alt_mode && take && cyc_addr[15:8] == 8'h08 &&
    cyc_kind inside {ixb_pkg::IXB_IO_RD, ixb_pkg::IXB_IO_WR} |-> ##[1:2] xbus_select_hi)
    else $error("port range select missing");
  c_zws: cover property (take && !zws_n_in);
  c_stretch: cover property (take && !iochrdy_in);
  c_bus_reset: cover property ($rose(bus_reset_out));
endmodule
`default_nettype wire

// [test/ixb_slave.sv]
`default_nettype none
// isa slave and xbus strap resistor
module ixb_slave (
  // clock and mode
  input wire logic  clk_sys,
  input wire logic  slow,
  input wire logic  fast,
  input wire logic  strap,
  // design side
  input wire logic  cyc_busy,
  input wire logic  xbus_read_n,
  input wire logic  xbus_read_n_oe_n,
  // pins
  output logic      iochrdy_in,
  output logic      zws_n_in,
  output logic      xrd_pin
);
  logic [4:0] cnt_q = 5'h00;
  always_ff @(posedge clk_sys)
    cnt_q <= cyc_busy ? cnt_q + 5'h01 : 5'h00;
  // slow slave holds ready low for 12 busy cycles
  assign iochrdy_in = !(slow && cnt_q < 5'h0c);
  assign zws_n_in   = !fast;
  assign xrd_pin    = xbus_read_n_oe_n ? strap : xbus_read_n;
endmodule
`default_nettype wire

// [test/isa_xbus_control_signals_test.sv]
`default_nettype none
module isa_xbus_control_signals_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst_n = 1'b0, cyc_start = 1'b0, cyc_dma = 1'b0;
  logic cyc_is_xbus = 1'b0, cyc_is_rom = 1'b0, dma_grant = 1'b0, dma_count_zero = 1'b0;
  logic pci_reset_n = 1'b1, hot_reset_set = 1'b0, reset_drive_set = 1'b0;
  logic power_good_in = 1'b0, mode_strap_in = 1'b1, slow = 1'b0, fast = 1'b0, strap = 1'b1;
  ixb_pkg::ixb_kind_t cyc_kind = ixb_pkg::IXB_MEM_RD;
  logic [15:0] cyc_addr = 16'h0000;
  logic [1:0]  cyc_xbus_dev = 2'h0;
  logic [2:0]  dma_channel = 3'h0;
  logic [31:0] break_event_enable = 32'h0, break_event_src = 32'h0;
  logic cyc_busy, cyc_done, bale_out, aen_out, tc_out, bus_reset_out, power_mgmt_active_n;
  logic xbus_read_n, xbus_read_n_oe_n, xbus_buffer_enable_n, xbus_select_lo, xbus_select_hi;
  logic alt_mode, strap_sense_bit, iochrdy_in, zws_n_in, xrd_pin;
  logic [2:0]  encoded_dma_ack;
  logic [4:0]  outs;
  logic [15:0] ad [4] = '{16'h07ff, 16'h0800, 16'h08ff, 16'h0900};
  int len, ld, failures = 0, n_compared = 0, cyc_n = 0;
  ixb_ctrl #(.RESET_CYC(20)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .cyc_start(cyc_start), .cyc_kind(cyc_kind),
    .cyc_addr(cyc_addr), .cyc_dma(cyc_dma), .cyc_is_xbus(cyc_is_xbus),
    .cyc_is_rom(cyc_is_rom), .cyc_xbus_dev(cyc_xbus_dev), .cyc_busy(cyc_busy),
    .cyc_done(cyc_done), .dma_grant(dma_grant), .dma_channel(dma_channel),
    .dma_count_zero(dma_count_zero), .pci_reset_n(pci_reset_n),
    .hot_reset_set(hot_reset_set), .reset_drive_set(reset_drive_set),
    .break_event_enable(break_event_enable), .break_event_src(break_event_src),
    .power_good_in(power_good_in), .mode_strap_in(mode_strap_in), .iochrdy_in(iochrdy_in),
    .zws_n_in(zws_n_in), .xbus_read_n_in(xrd_pin), .bale_out(bale_out), .aen_out(aen_out),
    .tc_out(tc_out), .encoded_dma_ack(encoded_dma_ack), .bus_reset_out(bus_reset_out),
    .power_mgmt_active_n(power_mgmt_active_n), .xbus_read_n(xbus_read_n),
    .xbus_read_n_oe_n(xbus_read_n_oe_n), .xbus_buffer_enable_n(xbus_buffer_enable_n),
    .xbus_select_lo(xbus_select_lo), .xbus_select_hi(xbus_select_hi), .alt_mode(alt_mode),
    .strap_sense_bit(strap_sense_bit));
  ixb_slave u_slave (.clk_sys(clk_sys), .slow(slow), .fast(fast), .strap(strap),
    .cyc_busy(cyc_busy), .xbus_read_n(xbus_read_n), .xbus_read_n_oe_n(xbus_read_n_oe_n),
    .iochrdy_in(iochrdy_in), .zws_n_in(zws_n_in), .xrd_pin(xrd_pin));
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc_n++;
    if (cyc_n == 3000)
    begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask
  // one isa cycle; outs = {aen, xoe_n, xrd_n, sel_hi, sel_lo}
  task automatic run(input ixb_pkg::ixb_kind_t k, input logic [15:0] a, input logic x, r, d);
    cyc_kind = k;
    cyc_addr = a;
    cyc_is_xbus = x;
    cyc_is_rom = r;
    cyc_dma = d;
    cyc_start = 1'b1;
    tk(1);
    cyc_start = 1'b0;
    for (len = 1; cyc_busy !== 1'b1 && len < 4; len++) tk(1);
    outs = {aen_out, xbus_buffer_enable_n, xbus_read_n, xbus_select_hi, xbus_select_lo};
    for (; cyc_done !== 1'b1 && len < 60; len++) tk(1);
    tk(1);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    tk(16);
    rst_n = 1'b1;
    tk(4);
    chk("alt_mode", 16'h1, alt_mode);
    chk("strap_bit", 16'h1, strap_sense_bit);
    chk("xrd_oe", 16'h0, xbus_read_n_oe_n);
    chk("ack_idle", 16'h4, encoded_dma_ack);
    power_good_in = 1'b1;
    for (len = 0; bus_reset_out !== 1'b1 && len < 5; len++) tk(1);
    for (len = 0; bus_reset_out === 1'b1 && len < 40; len++) tk(1);
    chk("rst_len", 16'h1, len >= 20 && len <= 22);
    for (int i = 0; i < 2; i++)
    begin
      {reset_drive_set, hot_reset_set} = 2'h1 << i;
      tk(1);
      {reset_drive_set, hot_reset_set} = 2'h0;
      tk(1);
      chk("rst_trig", 16'h1, bus_reset_out);
      tk(25);
      chk("rst_end", 16'h0, bus_reset_out);
    end
    pci_reset_n = 1'b0;
    tk(2);
    chk("pci_rst", 16'h1, bus_reset_out);
    pci_reset_n = 1'b1;
    tk(25);
    run(ixb_pkg::IXB_MEM_RD, 16'h0100, 1'b0, 1'b0, 1'b0);
    ld = len;
    chk("plain", 16'h0c, outs);
    fast = 1'b1;
    tk(3);
    run(ixb_pkg::IXB_MEM_RD, 16'h0100, 1'b0, 1'b0, 1'b0);
    chk("zws_len", 16'h1, len < ld);
    fast = 1'b0;
    slow = 1'b1;
    tk(3);
    run(ixb_pkg::IXB_MEM_RD, 16'h0100, 1'b0, 1'b0, 1'b0);
    chk("ready_len", 16'h1, len > ld + 4);
    slow = 1'b0;
    tk(3);
    run(ixb_pkg::IXB_MEM_RD, 16'h0000, 1'b1, 1'b1, 1'b0);
    chk("rom", 16'h01, outs);
    chk("rom_len", 16'(ld), 16'(len));
    for (int i = 0; i < 4; i++)
    begin
      run(ixb_pkg::IXB_IO_RD, ad[i], ad[i][15:8] == 8'h08, 1'b0, 1'b0);
      chk("range", ad[i][15:8] == 8'h08, outs[1]);
    end
    run(ixb_pkg::IXB_IO_WR, 16'h0810, 1'b1, 1'b0, 1'b0);
    chk("xrd_wr", 16'h1, outs[2]);
    run(ixb_pkg::IXB_MEM_WR, 16'h0200, 1'b0, 1'b0, 1'b1);
    chk("aen", 16'h1, outs[4]);
    for (int i = 0; i < 8; i++)
    begin
      dma_grant = 1'b1;
      dma_channel = 3'(i);
      dma_count_zero = (i == 7);
      tk(2);
      chk("ack", 16'(i), encoded_dma_ack);
      chk("tc", i == 7, tc_out);
    end
    dma_grant = 1'b0;
    dma_count_zero = 1'b0;
    tk(2);
    chk("ack_idle", 16'h4, encoded_dma_ack);
    rst_n = 1'b0;
    mode_strap_in = 1'b0;
    strap = 1'b0;
    tk(3);
    rst_n = 1'b1;
    tk(4);
    chk("pc_mode", 16'h0, alt_mode);
    hot_reset_set = 1'b1;
    tk(1);
    hot_reset_set = 1'b0;
    tk(2);
    chk("pc_no_rst", 16'h0, bus_reset_out);
    break_event_enable = 32'h20;
    break_event_src = 32'h01;
    tk(2);
    chk("brk_masked", 16'h1, power_mgmt_active_n);
    break_event_src = 32'h20;
    tk(2);
    chk("brk_active", 16'h0, power_mgmt_active_n);
    break_event_src = 32'h0;
    for (int i = 0; i < 4; i++)
    begin
      cyc_xbus_dev = 2'(i);
      run(ixb_pkg::IXB_IO_RD, 16'h0060, 1'b1, 1'b0, 1'b0);
      chk("xdev", 16'(i), outs[1:0]);
    end
    end_of_test();
  end
endmodule
bind ixb_ctrl ixb_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .cyc_start(cyc_start), .cyc_kind(cyc_kind),
  .cyc_addr(cyc_addr), .cyc_dma(cyc_dma), .cyc_is_xbus(cyc_is_xbus), .cyc_busy(cyc_busy),
  .cyc_done(cyc_done), .dma_grant(dma_grant), .dma_channel(dma_channel),
  .iochrdy_in(iochrdy_in), .zws_n_in(zws_n_in), .alt_mode(alt_mode), .bale_out(bale_out),
  .aen_out(aen_out), .encoded_dma_ack(encoded_dma_ack), .bus_reset_out(bus_reset_out),
  .power_mgmt_active_n(power_mgmt_active_n), .xbus_read_n(xbus_read_n),
  .xbus_buffer_enable_n(xbus_buffer_enable_n), .xbus_select_hi(xbus_select_hi));
`default_nettype wire
